/* verilog/pwq_defines.svh */
// Constants of the single-channel pulse generator with update quirks
`ifndef PWQ_DEFINES_SVH
`define PWQ_DEFINES_SVH
`define PWQ_CNT_W         16
`define PWQ_PRE_W         8
`define PWQ_CNT_ZERO      16'h0000
`define PWQ_CNT_ONE       16'h0001
`define PWQ_PERIOD_RST    16'h0010
`define PWQ_DUTY_RST      16'h0008
`define PWQ_PRE_RST       8'h00
`endif

/* verilog/pwq_pkg.sv */
// Types of the single-channel pulse generator with update quirks
package pwq_pkg;
  `include "pwq_defines.svh"
  typedef enum logic [1:0]
  {
    PWQ_IDLE  = 2'b00,
    PWQ_FIRST = 2'b01,
    PWQ_RUN   = 2'b11
  } pwq_state_type;
  typedef struct packed
  {
    pwq_state_type           state;
    logic [`PWQ_CNT_W-1:0]   counter;
    logic [`PWQ_CNT_W-1:0]   period;
    logic [`PWQ_CNT_W-1:0]   duty;
    logic [`PWQ_CNT_W-1:0]   pendVal;
    logic                    pendValid;
    logic                    pendIsPeriod;
    logic [`PWQ_PRE_W-1:0]   preCnt;
    logic                    tickSeen;
    logic                    enabledFlag;
    logic                    outLvl;
    logic                    upDown;
    logic                    periodDone;
  } pwq_regs_type;
endpackage

/* verilog/pwq_channel.sv */
// One pulse width channel with its update, start value and status quirks
`timescale 1ns/100ps
`include "pwq_defines.svh"
// What this block does
// - Update write applies at once while channel counter is 0 or 1.
// - With channel period 0, period updates are never applied.
// - Left-aligned counter starts at 0 first period, then at 1.
// - Duty 0 centered, or 0 or 1 left, may invert the waveform.
// - Disable before one channel clock period: output off, enabled flag stays 1.
module pwq_channel
#(
  parameter int CntW = `PWQ_CNT_W,
  parameter int PreW = `PWQ_PRE_W
)
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rstn,
  // Control
  input  wire logic                chanEnable,
  input  wire logic                chanDisable,
  input  wire logic                centerAligned,
  input  wire logic                polarityHigh,
  input  wire logic [PreW-1:0]     clockDivide,
  // Direct writes and the update write
  input  wire logic                periodWrite,
  input  wire logic                dutyWrite,
  input  wire logic                updateWrite,
  input  wire logic                updateIsPeriod,
  input  wire logic [CntW-1:0]     writeData,
  // Status and output
  output logic [CntW-1:0]          channelCounter,
  output logic [CntW-1:0]          channelPeriod,
  output logic [CntW-1:0]          channelDuty,
  output logic                     channelEnabledFlag,
  output logic                     periodDone,
  output logic                     pwmOut
);
  import pwq_pkg::*;

  pwq_regs_type regs_q;
  pwq_regs_type regs_d;

  function automatic logic cntLow(input logic [CntW-1:0] c);
    cntLow = (c == `PWQ_CNT_ZERO) || (c == `PWQ_CNT_ONE);
  endfunction

  always_comb
  begin
    logic            tick;
    logic            boundary;
    logic            doUpdate;
    logic [CntW-1:0] nextCnt;
    tick         = 1'b0;
    boundary     = 1'b0;
    doUpdate     = 1'b0;
    nextCnt      = regs_q.counter;
    regs_d       = regs_q;
    regs_d.periodDone = 1'b0;

    // Channel clock prescaler
    if (regs_q.state != PWQ_IDLE)
    begin
      if (regs_q.preCnt >= clockDivide)
      begin
        regs_d.preCnt = '0;
        tick          = 1'b1;
      end
      else
      begin
        regs_d.preCnt = regs_q.preCnt + 1'b1;
      end
    end

    unique case (regs_q.state)
      PWQ_IDLE:
      begin
        if (chanEnable)
        begin
          regs_d.state       = PWQ_FIRST;
          regs_d.counter     = `PWQ_CNT_ZERO;
          regs_d.upDown      = 1'b0;
          regs_d.preCnt      = '0;
          regs_d.tickSeen    = 1'b0;
          regs_d.enabledFlag = 1'b1;
        end
      end
      PWQ_FIRST, PWQ_RUN:
      begin
        if (tick)
        begin
          regs_d.tickSeen = 1'b1;
          if (centerAligned)
          begin
            if (!regs_q.upDown)
            begin
              if (regs_q.counter >= regs_q.period)
              begin
                regs_d.upDown = 1'b1;
                nextCnt       = regs_q.counter - 1'b1;
              end
              else
              begin
                nextCnt = regs_q.counter + 1'b1;
              end
            end
            else if (regs_q.counter <= `PWQ_CNT_ONE)
            begin
              boundary      = 1'b1;
              regs_d.upDown = 1'b0;
              nextCnt       = `PWQ_CNT_ZERO;
            end
            else
            begin
              nextCnt = regs_q.counter - 1'b1;
            end
          end
          else if (regs_q.counter >= regs_q.period)
          begin
            boundary = 1'b1;
            nextCnt  = `PWQ_CNT_ONE;
          end
          else
          begin
            nextCnt = regs_q.counter + 1'b1;
          end
          regs_d.counter = nextCnt;
          if (boundary)
          begin
            regs_d.state = PWQ_RUN;
            regs_d.periodDone = 1'b1;
          end
        end
        // Output comparison; extreme duty values fall out inverted
        regs_d.outLvl = (regs_q.counter < regs_q.duty) ? polarityHigh : ~polarityHigh;
        if (chanDisable)
        begin
          regs_d.state   = PWQ_IDLE;
          regs_d.outLvl  = 1'b0;
          regs_d.counter = `PWQ_CNT_ZERO;
          if (regs_q.tickSeen)
          begin
            regs_d.enabledFlag = 1'b0;
          end
          // Early disable leaves the flag stuck at 1
        end
      end
      default:
      begin
        regs_d.state = PWQ_IDLE;
      end
    endcase

    // Update write: captured, or applied at once at low counter values
    if (updateWrite)
    begin
      if (cntLow(regs_q.counter))
      begin
        doUpdate = 1'b1;
        regs_d.pendValid = 1'b0;
      end
      else
      begin
        regs_d.pendValid = 1'b1;
      end
      regs_d.pendVal      = writeData;
      regs_d.pendIsPeriod = updateIsPeriod;
    end
    else if (boundary && regs_q.pendValid)
    begin
      doUpdate         = 1'b1;
      regs_d.pendValid = 1'b0;
    end

    if (doUpdate)
    begin
      if (regs_d.pendIsPeriod)
      begin
        if (regs_q.period != `PWQ_CNT_ZERO)
        begin
          regs_d.period = regs_d.pendVal;
        end
      end
      else
      begin
        regs_d.duty = regs_d.pendVal;
      end
    end

    // Direct writes, taken only while the channel is stopped
    if (regs_q.state == PWQ_IDLE)
    begin
      if (periodWrite)
      begin
        regs_d.period = writeData;
      end
      if (dutyWrite)
      begin
        regs_d.duty = writeData;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regs_q <= '{state: PWQ_IDLE, counter: `PWQ_CNT_ZERO, period: `PWQ_PERIOD_RST,
                  duty: `PWQ_DUTY_RST, pendVal: `PWQ_CNT_ZERO, pendValid: 1'b0,
                  pendIsPeriod: 1'b0, preCnt: `PWQ_PRE_RST, tickSeen: 1'b0,
                  enabledFlag: 1'b0, outLvl: 1'b0, upDown: 1'b0, periodDone: 1'b0};
    end
    else
    begin
      regs_q <= regs_d;
    end
  end

  assign channelCounter     = regs_q.counter;
  assign channelPeriod      = regs_q.period;
  assign channelDuty        = regs_q.duty;
  assign channelEnabledFlag = regs_q.enabledFlag;
  assign periodDone         = regs_q.periodDone;
  assign pwmOut             = regs_q.outLvl;
endmodule

/* testbench/pwq_channel_props.sv */
// Port assertions of the pulse channel
`timescale 1ns/100ps
module pwq_channel_props
#(
  parameter int CntW = 16,
  parameter int PreW = 8
)
(
  input wire logic            clk,
  input wire logic            rstn,
  input wire logic            chanDisable,
  input wire logic            centerAligned,
  input wire logic [PreW-1:0] clockDivide,
  input wire logic            periodWrite,
  input wire logic            updateWrite,
  input wire logic            updateIsPeriod,
  input wire logic [CntW-1:0] writeData,
  input wire logic [CntW-1:0] channelCounter,
  input wire logic [CntW-1:0] channelPeriod,
  input wire logic [CntW-1:0] channelDuty,
  input wire logic            channelEnabledFlag,
  input wire logic            periodDone,
  input wire logic            pwmOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_imm;
    updateWrite && updateIsPeriod && channelCounter <= 1 && channelPeriod != 0
      |=> channelPeriod == $past(writeData);
  endproperty
  a_imm: assert property (p_imm) else $error("period update late");
  property p_zero;
    channelPeriod == 0 && !periodWrite |=> channelPeriod == 0;
  endproperty
  a_zero: assert property (p_zero) else $error("zero period updated");
  property p_first;
    $rose(channelEnabledFlag) && !centerAligned |-> channelCounter == 0;
  endproperty
  a_first: assert property (p_first) else $error("first start not 0");
  property p_rest;
    periodDone && !centerAligned |-> channelCounter == 1;
  endproperty
  a_rest: assert property (p_rest) else $error("restart not 1");
  property p_defer;
    updateWrite && !updateIsPeriod && !centerAligned && channelCounter > 1
      && channelCounter < channelPeriod |=> $stable(channelDuty);
  endproperty
  a_defer: assert property (p_defer) else $error("duty update early");
  property p_early;
    $rose(channelEnabledFlag) ##1 (chanDisable && clockDivide > 2)
      |=> channelEnabledFlag && !pwmOut;
  endproperty
  a_early: assert property (p_early) else $error("early disable flag");
endmodule

/* testbench/pwq_channel_tb.sv */
// Self-checking bench of the pulse channel
`timescale 1ns/100ps
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin nErrors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module pwq_channel_tb;
  logic        clk, rstn, chanEnable, chanDisable, periodWrite, dutyWrite, updateWrite;
  logic        updateIsPeriod, centerAligned, polarityHigh, channelEnabledFlag;
  logic        periodDone, pwmOut;
  logic [7:0]  clockDivide;
  logic [15:0] writeData, channelCounter, channelPeriod, channelDuty;
  int          nErrors, numChecks;
  pwq_channel i_pwq_channel
  (
    .clk                (clk),
    .rstn               (rstn),
    .chanEnable         (chanEnable),
    .chanDisable        (chanDisable),
    .centerAligned      (centerAligned),
    .polarityHigh       (polarityHigh),
    .clockDivide        (clockDivide),
    .periodWrite        (periodWrite),
    .dutyWrite          (dutyWrite),
    .updateWrite        (updateWrite),
    .updateIsPeriod     (updateIsPeriod),
    .writeData          (writeData),
    .channelCounter     (channelCounter),
    .channelPeriod      (channelPeriod),
    .channelDuty        (channelDuty),
    .channelEnabledFlag (channelEnabledFlag),
    .periodDone         (periodDone),
    .pwmOut             (pwmOut)
  );
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic u, logic p, logic [15:0] d);
    @(posedge clk);
    updateWrite <= u;
    periodWrite <= !u && p;
    dutyWrite <= !u && !p;
    updateIsPeriod <= p;
    writeData <= d;
    @(posedge clk);
    {updateWrite, periodWrite, dutyWrite} <= '0;
    #1;
  endtask
  task automatic ctl(logic e, logic d);
    @(posedge clk);
    chanEnable <= e;
    chanDisable <= d;
    @(posedge clk);
    {chanEnable, chanDisable} <= '0;
    #1;
  endtask
  task automatic waitFor(logic [15:0] v, logic done);
    int k;
    for (k = 0; k < 200 && channelCounter !== v && !(done && periodDone === 1); k++)
      tick();
    if (k == 200)
    begin
      nErrors++;
      close_out();
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    nErrors++;
    close_out();
  end
  initial
  begin
    {rstn, chanEnable, chanDisable, periodWrite, dutyWrite, updateWrite} = '0;
    {updateIsPeriod, centerAligned, writeData} = '0;
    polarityHigh = 1;
    clockDivide = 8'h03;
    repeat (4) @(posedge clk);
    rstn <= 1;
    tick();
    `CHK({channelPeriod, channelDuty, channelCounter, channelEnabledFlag, pwmOut}, 50'h40_0020_0000)
    wr(0, 1, 16'h0008);
    ctl(1, 0);
    `CHK(channelCounter, 16'h0000)
    waitFor(16'h0002, 0);
    wr(1, 0, 16'h0002);
    `CHK(channelDuty, 16'h0008)
    waitFor(16'hffff, 1);
    `CHK({channelDuty, channelCounter}, 32'h0002_0001)
    wr(1, 1, 16'h000c);
    `CHK(channelPeriod, 16'h000c)
    `CHK(pwmOut, 1'b1)
    tick(20);
    `CHK(pwmOut, 1'b0)
    ctl(0, 1);
    `CHK({channelEnabledFlag, pwmOut, channelCounter}, 18'h00000)
    ctl(1, 0);
    ctl(0, 1);
    `CHK({channelEnabledFlag, pwmOut, channelCounter}, 18'h20000)
    wr(0, 1, 16'h0000);
    wr(1, 1, 16'h0005);
    `CHK(channelPeriod, 16'h0000)
    @(posedge clk);
    centerAligned <= 1'b1;
    polarityHigh  <= 1'b0;
    clockDivide   <= 8'h00;
    wr(0, 1, 16'h0004);
    wr(0, 0, 16'h0002);
    ctl(1, 0);
    tick(4);
    `CHK({channelCounter, pwmOut}, 17'h00009)
    wr(1, 0, 16'h0003);
    `CHK(channelDuty, 16'h0002)
    tick(2);
    `CHK({channelDuty, channelCounter, periodDone}, 33'h0_0006_0001)
    close_out();
  end
endmodule
bind pwq_channel pwq_channel_props #(.CntW(CntW), .PreW(PreW)) i_pwq_channel_props
(
  .clk                (clk),
  .rstn               (rstn),
  .chanDisable        (chanDisable),
  .centerAligned      (centerAligned),
  .clockDivide        (clockDivide),
  .periodWrite        (periodWrite),
  .updateWrite        (updateWrite),
  .updateIsPeriod     (updateIsPeriod),
  .writeData          (writeData),
  .channelCounter     (channelCounter),
  .channelPeriod      (channelPeriod),
  .channelDuty        (channelDuty),
  .channelEnabledFlag (channelEnabledFlag),
  .periodDone         (periodDone),
  .pwmOut             (pwmOut)
);
